// file: core/phy_mmd_params.svh
// Constants for the indirect management register block.
// Notes on behaviour
// - Burst interval low half is RW, resets to 8 ms code, 0x1A80 gives 16 ms.
// - Burst interval high half is RW, resets to 8 ms code, 0x0006 gives 16 ms.
// - Gigabit link-up time field sits in bits 3 to 1 and resets to 100.
// - Link-up time field is accessible only while basic control equals 0x2100.
// - Common control bit 4 is a write-only LED style override that reads zero.
// - Writing the override bit copies its value into LED style status bit 3.
// - LED style status takes the strap at reset; only the override changes it.
// - Portal control holds device address in 4:0 and access type in 15:14.
// - Portal data is the register address in setup mode, else register contents.
`ifndef PHY_MMD_PARAMS_SVH
`define PHY_MMD_PARAMS_SVH
`define REG_PORTAL_CTRL     5'h0D
`define REG_PORTAL_DATA     5'h0E
`define DEV_AUTONEG         5'h00
`define DEV_PMA             5'h01
`define DEV_VENDOR          5'h02
`define IDX_BURST_LOW       16'h0003
`define IDX_BURST_HIGH      16'h0004
`define IDX_LINKUP_TIME     16'h005A
`define IDX_COMMON_CTRL     16'h0000
`define BURST_LOW_8MS       16'h4000
`define BURST_LOW_16MS      16'h1A80
`define BURST_HIGH_8MS      16'h0003
`define BURST_HIGH_16MS     16'h0006
`define LINKUP_RESET        16'h0108
`define LINKUP_RW_MASK      16'h01FF
`define LINKUP_FIELD_MASK   16'h000E
`define FORCED_100TX        16'h2100
`define COMMON_RW_MASK      16'hFFE7
`define LED_OVERRIDE_BIT    4
`define LED_STATUS_BIT      3
`endif

// file: core/phy_mmd_pkg.sv
// Types shared by the indirect management register block.
package phy_mmd_pkg;
    typedef enum logic [1:0] {
        ACC_ADDRESS  = 2'h0,
        ACC_DATA     = 2'h1,
        ACC_INC_RW   = 2'h2,
        ACC_INC_WR   = 2'h3
    } access_mode_t;
endpackage : phy_mmd_pkg

// file: core/phy_mmd_regs.sv
// Indirect register portal with burst interval, link-up time and LED style registers.
`timescale 1ns/1ps
`include "phy_mmd_params.svh"
module phy_mmd_regs
    import phy_mmd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [4:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic [15:0] basicControl,
    input  wire logic        ledStrap,
    output logic      [15:0] regRdata,
    output logic             regRvalid,
    output logic             ledIndicatorStyle,
    output logic      [2:0]  linkupTime,
    output logic             flpInterval16ms
);
    access_mode_t accessMode_reg;
    logic [8:0]   ctrlReserved_reg;
    logic [4:0]   devAddr_reg;
    logic [15:0]  regIndex_reg;
    logic [15:0]  burstLow_reg;
    logic [15:0]  burstHigh_reg;
    logic [15:0]  linkup_reg;
    logic [15:0]  common_reg;
    logic         ledStyle_reg;
    logic [15:0]  indirData;
    logic         dataWr;
    logic         dataRd;
    logic         selBurstLow;
    logic         selBurstHigh;
    logic         selLinkup;
    logic         selCommon;
    logic         linkupOpen;
    logic [15:0]  linkupMask;

    // Portal data accesses reach an indirect register; setup mode only moves the index.
    assign dataWr       = regWrite && regAddr == `REG_PORTAL_DATA && accessMode_reg != ACC_ADDRESS;
    assign dataRd       = regRead && regAddr == `REG_PORTAL_DATA && accessMode_reg != ACC_ADDRESS;
    assign selBurstLow  = devAddr_reg == `DEV_AUTONEG && regIndex_reg == `IDX_BURST_LOW;
    assign selBurstHigh = devAddr_reg == `DEV_AUTONEG && regIndex_reg == `IDX_BURST_HIGH;
    assign selLinkup    = devAddr_reg == `DEV_PMA && regIndex_reg == `IDX_LINKUP_TIME;
    assign selCommon    = devAddr_reg == `DEV_VENDOR && regIndex_reg == `IDX_COMMON_CTRL;
    assign linkupOpen   = basicControl == `FORCED_100TX;
    // The field bits drop out of the writable set unless 100BASE-TX is forced.
    assign linkupMask   = linkupOpen ? `LINKUP_RW_MASK : (`LINKUP_RW_MASK & ~`LINKUP_FIELD_MASK);

    always_comb begin
        indirData = 16'h0000;
        if (selBurstLow) begin
            indirData = burstLow_reg;
        end else if (selBurstHigh) begin
            indirData = burstHigh_reg;
        end else if (selLinkup) begin
            indirData = linkup_reg & linkupMask;
        end else if (selCommon) begin
            indirData = (common_reg & `COMMON_RW_MASK) | {12'h000, ledStyle_reg, 3'h0};
        end
    end

    // Reserved control bits are kept so that software reads back what it wrote.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            accessMode_reg   <= ACC_ADDRESS;
            ctrlReserved_reg <= 9'h000;
            devAddr_reg      <= 5'h00;
        end else if (regWrite && regAddr == `REG_PORTAL_CTRL) begin
            accessMode_reg   <= access_mode_t'(regWdata[15:14]);
            ctrlReserved_reg <= regWdata[13:5];
            devAddr_reg      <= regWdata[4:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            regIndex_reg <= 16'h0000;
        end else if (regWrite && regAddr == `REG_PORTAL_DATA && accessMode_reg == ACC_ADDRESS) begin
            regIndex_reg <= regWdata;
        end else if ((dataWr && accessMode_reg != ACC_DATA)
                     || (dataRd && accessMode_reg == ACC_INC_RW)) begin
            regIndex_reg <= regIndex_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            burstLow_reg  <= `BURST_LOW_8MS;
            burstHigh_reg <= `BURST_HIGH_8MS;
        end else if (dataWr && selBurstLow) begin
            burstLow_reg  <= regWdata;
        end else if (dataWr && selBurstHigh) begin
            burstHigh_reg <= regWdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            linkup_reg <= `LINKUP_RESET;
        end else if (dataWr && selLinkup) begin
            linkup_reg <= (linkup_reg & ~linkupMask) | (regWdata & linkupMask);
        end
    end

    // The strap is taken by the synchronous reset, so it is sampled on a clock edge.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            common_reg   <= 16'h0000;
            ledStyle_reg <= ledStrap;
        end else if (dataWr && selCommon) begin
            common_reg   <= regWdata & `COMMON_RW_MASK;
            ledStyle_reg <= regWdata[`LED_OVERRIDE_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            regRdata  <= 16'h0000;
            regRvalid <= 1'b0;
        end else begin
            regRvalid <= regRead;
            if (!regRead) begin
                regRdata <= 16'h0000;
            end else if (regAddr == `REG_PORTAL_CTRL) begin
                regRdata <= {accessMode_reg, ctrlReserved_reg, devAddr_reg};
            end else if (regAddr == `REG_PORTAL_DATA) begin
                regRdata <= (accessMode_reg == ACC_ADDRESS) ? regIndex_reg : indirData;
            end else begin
                regRdata <= 16'h0000;
            end
        end
    end

    // Mirrors for the PHY core; the timer only needs the high half to tell 8 ms from 16 ms.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ledIndicatorStyle <= 1'b0;
            linkupTime        <= 3'b100;
            flpInterval16ms   <= 1'b0;
        end else begin
            ledIndicatorStyle <= ledStyle_reg;
            linkupTime        <= linkup_reg[3:1];
            flpInterval16ms   <= burstHigh_reg == `BURST_HIGH_16MS;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_burst_low_reset: assert property ($past(!rst_b) |-> burstLow_reg == `BURST_LOW_8MS)
        else $error("Burst low half did not reset to the 8 ms code.");
    a_burst_high_reset: assert property ($past(!rst_b) |-> burstHigh_reg == `BURST_HIGH_8MS)
        else $error("Burst high half did not reset to the 8 ms code.");
    a_linkup_reset: assert property ($past(!rst_b) |-> linkup_reg[3:1] == 3'b100)
        else $error("Link-up time field did not reset to 100.");
    a_linkup_gate: assert property (dataWr && selLinkup && !linkupOpen |=> $stable(linkup_reg[3:1]))
        else $error("Link-up time field changed while not forced 100BASE-TX.");
    a_led_wo_read: assert property (dataRd && selCommon |=> regRvalid && !regRdata[4])
        else $error("LED override bit read back nonzero.");
    a_led_copy: assert property (dataWr && selCommon |=> ##1 ledIndicatorStyle == $past(regWdata[4], 2))
        else $error("LED style status did not follow the override write.");
    a_led_hold: assert property (!(dataWr && selCommon) |=> $stable(ledStyle_reg))
        else $error("LED style status changed without an override write.");
    a_index_incr: assert property (dataWr && accessMode_reg != ACC_DATA
        |=> regIndex_reg == $past(regIndex_reg) + 16'h0001)
        else $error("Register index did not post-increment.");
    a_index_setup: assert property (regWrite && regAddr == `REG_PORTAL_DATA
        && accessMode_reg == ACC_ADDRESS |=> regIndex_reg == $past(regWdata))
        else $error("Setup write did not load the register index.");
    a_burst_read: assert property (dataRd && selBurstLow |=> regRdata == $past(burstLow_reg))
        else $error("Burst low read did not return the stored value.");
    // Every read strobe gets exactly one valid pulse, and the data bus idles at zero.
    a_read_answer: assert property (regRead |=> regRvalid)
        else $error("Read strobe got no valid pulse.");
    a_read_idle: assert property (!regRead |=> !regRvalid && regRdata == 16'h0000)
        else $error("Read data did not idle at zero.");
    a_burst_high_read: assert property (dataRd && selBurstHigh
        |=> regRdata == $past(burstHigh_reg))
        else $error("Burst high read did not return the stored value.");
    a_burst_low_store: assert property (dataWr && selBurstLow
        |=> burstLow_reg == $past(regWdata))
        else $error("Burst low write was not stored.");
    a_burst_high_store: assert property (dataWr && selBurstHigh
        |=> burstHigh_reg == $past(regWdata))
        else $error("Burst high write was not stored.");
    a_linkup_hidden: assert property (dataRd && selLinkup && !linkupOpen
        |=> regRdata[3:1] == 3'b000)
        else $error("Link-up time field was visible while not forced 100BASE-TX.");
    a_linkup_open: assert property (dataWr && selLinkup && linkupOpen
        |=> linkup_reg[3:1] == $past(regWdata[3:1]))
        else $error("Link-up time field missed a write in forced 100BASE-TX.");
    a_led_status_read: assert property (dataRd && selCommon
        |=> regRdata[3] == $past(ledStyle_reg))
        else $error("LED style status bit read back wrong.");
    a_led_strap: assert property ($past(!rst_b) |-> ledStyle_reg == $past(ledStrap))
        else $error("LED style status did not take the strap at reset.");
    // Mirrors lag their source by one edge, so the first edge after reset is skipped.
    a_flp_mirror: assert property ($past(rst_b)
        |-> flpInterval16ms == ($past(burstHigh_reg) == `BURST_HIGH_16MS))
        else $error("Burst interval output does not follow the high half.");
    a_linkup_mirror: assert property ($past(rst_b)
        |-> linkupTime == $past(linkup_reg[3:1]))
        else $error("Link-up time output does not follow the field.");
    a_led_mirror: assert property ($past(rst_b)
        |-> ledIndicatorStyle == $past(ledStyle_reg))
        else $error("LED style output does not follow the status bit.");
    a_index_hold: assert property (dataWr && accessMode_reg == ACC_DATA
        |=> $stable(regIndex_reg))
        else $error("Register index moved in data mode without increment.");
    a_index_wr_only: assert property (dataRd && !regWrite && accessMode_reg == ACC_INC_WR
        |=> $stable(regIndex_reg))
        else $error("Register index moved on a read in write-increment mode.");


    c_burst_16ms: cover property (dataWr && selBurstHigh && regWdata == `BURST_HIGH_16MS);
    c_led_override: cover property (dataWr && selCommon && regWdata[4] != ledStyle_reg);
    c_linkup_open: cover property (dataWr && selLinkup && linkupOpen);
    c_inc_read: cover property (dataRd && accessMode_reg == ACC_INC_RW);
endmodule : phy_mmd_regs

// file: testbench/mgmt_master.sv
// Management controller model that drives the register portal strobes.
`timescale 1ns/1ps
module mgmt_master (
    input  wire logic        core_clk,
    input  wire logic [15:0] regRdata,
    input  wire logic        regRvalid,
    output logic             regWrite,
    output logic             regRead,
    output logic      [4:0]  regAddr,
    output logic      [15:0] regWdata
);
    initial begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regAddr  = 5'h00;
        regWdata = 16'h0000;
    end
    // Idle address and data are inverted so the design cannot lean on stale values.
    task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q);
        @(posedge core_clk);
        regWrite <= wr;
        regRead  <= !wr;
        regAddr  <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
        regRead  <= 1'b0;
        regAddr  <= ~a;
        regWdata <= ~d;
        // The answer is registered, so it is taken at the edge after the read strobe.
        if (!wr) begin
            @(posedge core_clk);
            q = (regRvalid === 1'b1) ? regRdata : 16'hXXXX;
        end
    endtask : xfer
endmodule : mgmt_master

// file: testbench/phy_mmd_timing_led_control_regs_tb_top.sv
// Self-checking bench for the indirect management register block.
`timescale 1ns/1ps
`include "phy_mmd_params.svh"
module phy_mmd_timing_led_control_regs_tb_top
    import phy_mmd_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ledStrap = 1'b1;
    logic [15:0] basicControl = 16'h0000;
    logic [15:0] regRdata, regWdata, q;
    logic [4:0] regAddr;
    logic regWrite, regRead, regRvalid, ledIndicatorStyle, flpInterval16ms;
    logic [2:0] linkupTime;
    int n_errors = 0;
    int compares = 0;
    always #20 core_clk = ~core_clk;
    phy_mmd_regs dut (.core_clk(core_clk), .rst_b(rst_b), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
        .basicControl(basicControl), .ledStrap(ledStrap), .regRdata(regRdata),
        .regRvalid(regRvalid), .ledIndicatorStyle(ledIndicatorStyle),
        .linkupTime(linkupTime), .flpInterval16ms(flpInterval16ms));
    mgmt_master host (.core_clk(core_clk), .regRdata(regRdata), .regRvalid(regRvalid),
        .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        host.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [15:0] exp);
        host.xfer(1'b0, `REG_PORTAL_DATA, 16'h0000, q);
        chk(q, exp);
    endtask : rd
    task automatic sel(input logic [4:0] dev, input logic [15:0] idx, input access_mode_t m);
        wr(`REG_PORTAL_CTRL, {ACC_ADDRESS, 9'h000, dev});
        wr(`REG_PORTAL_DATA, idx);
        wr(`REG_PORTAL_CTRL, {m, 9'h000, dev});
    endtask : sel
    task automatic t_reset;
        sel(`DEV_AUTONEG, `IDX_BURST_LOW, ACC_INC_RW);
        rd(`BURST_LOW_8MS);
        rd(`BURST_HIGH_8MS);
        chk({15'h0000, flpInterval16ms}, 16'h0000);
        chk({13'h0000, linkupTime}, 16'h0004);
        chk({15'h0000, ledIndicatorStyle}, 16'h0001);
        $display("test reset values done");
    endtask : t_reset
    task automatic t_burst;
        sel(`DEV_AUTONEG, `IDX_BURST_LOW, ACC_INC_WR);
        wr(`REG_PORTAL_DATA, `BURST_LOW_16MS);
        wr(`REG_PORTAL_DATA, `BURST_HIGH_16MS);
        sel(`DEV_AUTONEG, `IDX_BURST_LOW, ACC_INC_WR);
        rd(`BURST_LOW_16MS);
        rd(`BURST_LOW_16MS);
        chk({15'h0000, flpInterval16ms}, 16'h0001);
        sel(`DEV_AUTONEG, `IDX_BURST_HIGH, ACC_DATA);
        rd(`BURST_HIGH_16MS);
        wr(`REG_PORTAL_DATA, `BURST_HIGH_8MS);
        rd(`BURST_HIGH_8MS);
        chk({15'h0000, flpInterval16ms}, 16'h0000);
        $display("test burst interval done");
    endtask : t_burst
    task automatic t_linkup;
        sel(`DEV_PMA, `IDX_LINKUP_TIME, ACC_DATA);
        rd(16'h0100);
        wr(`REG_PORTAL_DATA, 16'h0104);
        rd(16'h0100);
        chk({13'h0000, linkupTime}, 16'h0004);
        @(posedge core_clk);
        basicControl <= `FORCED_100TX;
        rd(`LINKUP_RESET);
        wr(`REG_PORTAL_DATA, 16'h0104);
        rd(16'h0104);
        chk({13'h0000, linkupTime}, 16'h0002);
        $display("test link-up time done");
    endtask : t_linkup
    task automatic t_led;
        sel(`DEV_VENDOR, `IDX_COMMON_CTRL, ACC_DATA);
        rd(16'h0008);
        wr(`REG_PORTAL_DATA, 16'h0000);
        rd(16'h0000);
        chk({15'h0000, ledIndicatorStyle}, 16'h0000);
        wr(`REG_PORTAL_DATA, 16'h0010);
        rd(16'h0008);
        chk({15'h0000, ledIndicatorStyle}, 16'h0001);
        wr(`REG_PORTAL_DATA, 16'hFFF7);
        rd(16'hFFEF);
        host.xfer(1'b0, `REG_PORTAL_CTRL, 16'h0000, q);
        chk(q, {ACC_DATA, 9'h000, `DEV_VENDOR});
        $display("test led style done");
    endtask : t_led
    // Burst low, link-up and LED style registers hold non-reset values here, and the strap is low, so a reset must show.
    task automatic t_midreset;
        @(posedge core_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        sel(`DEV_AUTONEG, `IDX_BURST_LOW, ACC_DATA);
        rd(`BURST_LOW_8MS);
        chk({13'h0000, linkupTime}, 16'h0004);
        chk({15'h0000, ledIndicatorStyle}, 16'h0000);
        $display("test mid-run reset done");
    endtask : t_midreset
    task automatic wrap_up;
        $display("compares %0d, n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        // The strap moves after reset so a status that still follows it is caught.
        ledStrap <= 1'b0;
        t_reset();
        t_burst();
        t_linkup();
        t_led();
        t_midreset();
        wrap_up();
    end
    initial begin
        repeat (3000) @(posedge core_clk);
        n_errors++;
        wrap_up();
    end
endmodule : phy_mmd_timing_led_control_regs_tb_top
